/* File: hdl/power_mode_defs.vh */
// Purpose: Constants for the power mode sequencer
// Assumes: 8-bit register port, 20 MHz main oscillator clock
// Notes:
// How it works
// - Line two selector codes 00..11 pick port B pins 3..6; reset 00.
// - Line two on port B pin 4 cannot wake from Halt.
// - Line one selector codes 00..11 pick port A pins 4..7; reset 11.
// - Line zero selector codes 00..11 pick port A pins 0..3; reset 00.
// - After reset: Run mode, CPU and peripherals on oscillator divided by 2.
// - Slow mode bit set divides oscillator by 32; clearing restores normal.
// - Wait while slow gives Slow-Wait: CPU stopped, peripherals on slow clock.
// - Wait instruction stops CPU, clears mask, resumes on interrupt or reset.
// - Taking interrupt sets mask; popping condition codes clears it.
// - Halt instruction enters Halt only without Active-halt and auto-wakeup.
// - Halt exit restarts oscillator, waits 256 or 4096 CPU cycles first.
// - Entering Halt clears the mask so pending interrupts wake at once.
// - Halt stops the oscillator, CPU and all peripherals.
// - Watchdog-in-halt option makes halt with watchdog on give a watchdog reset.
// - Opcode 8E is decoded as the halt instruction.
// - Active-halt chosen by timebase-one enable, or overflow enable with CK1=0, CK0=1.
// - Reset ending Active-halt waits 256 or 4096 cycles, then fetches reset vector.
// - Interrupt ending Active-halt resumes at once, no stabilisation delay.
// - Entering Active-halt clears the mask.
// - Active-halt keeps only oscillator and selected timer counter running.
// - Halt with Active-halt enabled never gives a watchdog reset.
// - Only timebase-one and capable interrupts wake from Active-halt.
// - Halt with auto-wakeup enable set, without Active-halt or watchdog-in-halt reset, enters auto-wakeup-from-halt mode.
`ifndef POWER_MODE_DEFS_VH
`define POWER_MODE_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define WAKE_PIN_SELECT_ADDR  2'h0
`define MAIN_CLOCK_CTRL_ADDR 2'h1
`define TIMER_CTRL_ADDR      2'h2
`define MODE_STATUS_ADDR     2'h3

// ****************************************
// Field positions
// ****************************************
`define SEL_LINE_ZERO_LSB 0
`define SEL_LINE_ONE_LSB  2
`define SEL_LINE_TWO_LSB  4
`define CLK_SLOW_BIT      0
`define CLK_AWU_BIT       1
`define TMR_TIMEBASE_ONE_IRQ_ENABLE_BIT     0
`define TMR_OVERFLOW_IRQ_ENABLE_BIT     1
`define TMR_CK0_BIT       2
`define TMR_CK1_BIT       3

// ****************************************
// Reset values and codes
// ****************************************
`define WAKE_PIN_SELECT_RST 8'h0C
`define CTRL_RST            8'h00
`define HALT_OPCODE         8'h8E
`define LINE_TWO_NO_HALT    2'h1

// ****************************************
// Timing counts
// ****************************************
`define NORMAL_DIV     32'd2
`define SLOW_DIV       32'd32
`define STAB_SHORT_CYC 256
`define STAB_LONG_CYC  4096

`endif

/* File: hdl/power_mode_sequencer.v */
// Purpose: Run, Slow, Wait, Halt, Active-halt and auto-wakeup sequencing
// Assumes: clk_i is the main oscillator; CPU and interrupt logic outside
// Notes: Clock gating is given as one-cycle enables
//
// Chosen here: the address-and-strobe port and the register offsets.
`include "power_mode_defs.vh"
`default_nettype none

module power_mode_sequencer #(
  parameter integer STAB_SHORT = `STAB_SHORT_CYC,
  parameter integer STAB_LONG  = `STAB_LONG_CYC
) (
  // Clock and reset
  input  wire       clk_i,
  input  wire       sys_rst_i,
  // Register port
  input  wire [1:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output wire [7:0] rdata_o,
  // CPU instruction and interrupt handshake
  input  wire       instr_valid_i,
  input  wire [7:0] opcode_i,
  input  wire       wfi_exec_i,
  input  wire       irq_take_i,
  input  wire       cc_pop_i,
  input  wire       irq_pending_i,
  // Wake sources
  input  wire [2:0] ext_irq_i,
  input  wire       periph_halt_wake_i,
  input  wire       awu_irq_i,
  input  wire       timebase_one_interrupt_i,
  input  wire       ahalt_cap_irq_i,
  input  wire       ext_rst_req_i,
  // Pins and static options
  input  wire [7:0] port_a_i,
  input  wire [6:3] port_b_i,
  input  wire       wdg_enable_i,
  input  wire       watchdog_in_halt_option_i,
  input  wire       stab_long_i,
  // Clock controls and events
  output wire       osc_run_o,
  output wire       cpu_clk_en_o,
  output wire       periph_clk_en_o,
  output wire       timer_clk_en_o,
  output wire       imask_o,
  output wire [2:0] mode_o,
  output wire [2:0] wake_line_o,
  output wire       fetch_reset_o,
  output wire       service_irq_o,
  output wire       wdg_reset_o
);

  // ****************************************
  // States
  // ****************************************
  localparam [2:0] ST_RUN   = 3'h0;
  localparam [2:0] ST_WAIT  = 3'h1;
  localparam [2:0] ST_HALT  = 3'h2;
  localparam [2:0] ST_AHALT = 3'h3;
  localparam [2:0] ST_AUTO_WAKEUP_HALT_MODE = 3'h4;
  localparam [2:0] ST_STABI = 3'h5;
  localparam [2:0] ST_STABR = 3'h6;

  localparam [31:0] SLOW_LAST_W  = `SLOW_DIV - 32'd1;
  localparam [31:0] NORM_LAST_W  = `NORMAL_DIV - 32'd1;
  localparam [31:0] SHORT_LAST_W = STAB_SHORT - 1;
  localparam [31:0] LONG_LAST_W  = STAB_LONG - 1;
  localparam [4:0]  SLOW_LAST    = SLOW_LAST_W[4:0];
  localparam [4:0]  NORM_LAST    = NORM_LAST_W[4:0];
  localparam [12:0] SHORT_LAST   = SHORT_LAST_W[12:0];
  localparam [12:0] LONG_LAST    = LONG_LAST_W[12:0];

  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0]  sel_ff;
  reg  [7:0]  clk_ctrl_ff;
  reg  [7:0]  tmr_ctrl_ff;
  reg  [7:0]  rdata_ff;
  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg         imask_ff;
  reg  [4:0]  div_ff;
  reg  [12:0] stab_ff;
  reg  [7:0]  pa_meta_ff;
  reg  [7:0]  pa_ff;
  reg  [3:0]  pb_meta_ff;
  reg  [3:0]  pb_ff;
  reg         rst_meta_ff;
  reg         rst_ff;
  reg  [2:0]  wake_ff;
  reg         osc_ff;
  reg         cpu_en_ff;
  reg         per_en_ff;
  reg         tmr_en_ff;
  reg         fetch_ff;
  reg         svc_ff;
  reg         wdg_ff;

  wire [1:0] sel0 = sel_ff[`SEL_LINE_ZERO_LSB +: 2];
  wire [1:0] sel1 = sel_ff[`SEL_LINE_ONE_LSB +: 2];
  wire [1:0] sel2 = sel_ff[`SEL_LINE_TWO_LSB +: 2];
  wire       slow = clk_ctrl_ff[`CLK_SLOW_BIT];
  wire       awu_en = clk_ctrl_ff[`CLK_AWU_BIT];

  // ****************************************
  // Register port
  // ****************************************
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      sel_ff      <= `WAKE_PIN_SELECT_RST;
      clk_ctrl_ff <= `CTRL_RST;
      tmr_ctrl_ff <= `CTRL_RST;
      rdata_ff    <= 8'h00;
    end else begin
      if (wr_i) begin
        case (addr_i)
          `WAKE_PIN_SELECT_ADDR: sel_ff <= wdata_i;
          `MAIN_CLOCK_CTRL_ADDR: clk_ctrl_ff <= {6'h00, wdata_i[1:0]};
          `TIMER_CTRL_ADDR:      tmr_ctrl_ff <= {4'h0, wdata_i[3:0]};
          default: ;
        endcase
      end
      if (rd_i) begin
        case (addr_i)
          `WAKE_PIN_SELECT_ADDR: rdata_ff <= sel_ff;
          `MAIN_CLOCK_CTRL_ADDR: rdata_ff <= clk_ctrl_ff;
          `TIMER_CTRL_ADDR:      rdata_ff <= tmr_ctrl_ff;
          `MODE_STATUS_ADDR:     rdata_ff <= {3'h0, imask_ff, state_ff == ST_WAIT && slow, state_ff};
          default:               rdata_ff <= 8'h00;
        endcase
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  // ****************************************
  // Pin synchronisers and wake line mux
  // ****************************************
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pa_meta_ff  <= 8'h00;
      pa_ff       <= 8'h00;
      pb_meta_ff  <= 4'h0;
      pb_ff       <= 4'h0;
      rst_meta_ff <= 1'b0;
      rst_ff      <= 1'b0;
      wake_ff     <= 3'h0;
    end else begin
      pa_meta_ff  <= port_a_i;
      pa_ff       <= pa_meta_ff;
      pb_meta_ff  <= port_b_i;
      pb_ff       <= pb_meta_ff;
      rst_meta_ff <= ext_rst_req_i;
      rst_ff      <= rst_meta_ff;
      wake_ff[0]  <= pa_ff[{1'b0, sel0}];
      wake_ff[1]  <= pa_ff[{1'b1, sel1}];
      wake_ff[2]  <= pb_ff[sel2];
    end
  end

  // ****************************************
  // Mode decisions
  // ****************************************
  wire halt_instr = instr_valid_i && (opcode_i == `HALT_OPCODE);
  wire ahalt_en = tmr_ctrl_ff[`TMR_TIMEBASE_ONE_IRQ_ENABLE_BIT] ||
                  (tmr_ctrl_ff[`TMR_OVERFLOW_IRQ_ENABLE_BIT] && !tmr_ctrl_ff[`TMR_CK1_BIT] &&
                   tmr_ctrl_ff[`TMR_CK0_BIT]);
  wire wdg_trip = wdg_enable_i && watchdog_in_halt_option_i;
  // Line two on pin 4 is blind in Halt
  wire [2:0] ext_q = {ext_irq_i[2] && (sel2 != `LINE_TWO_NO_HALT),
                      ext_irq_i[1:0]};
  wire halt_wake  = (|ext_q) || periph_halt_wake_i;
  wire ahalt_wake = timebase_one_interrupt_i || ahalt_cap_irq_i;
  wire [12:0] stab_last = stab_long_i ? LONG_LAST : SHORT_LAST;
  wire [4:0] div_last = (slow && state_ff != ST_STABI && state_ff != ST_STABR)
                        ? SLOW_LAST : NORM_LAST;
  // Catches up at once when the divide ratio shrinks
  wire tick = (div_ff >= div_last);

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (halt_instr) begin
          if (ahalt_en)
            nxt_state = ST_AHALT;
          else if (wdg_trip)
            nxt_state = ST_RUN;
          else if (awu_en)
            nxt_state = ST_AUTO_WAKEUP_HALT_MODE;
          else
            nxt_state = ST_HALT;
        end else if (wfi_exec_i) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (irq_pending_i)
          nxt_state = ST_RUN;
      end
      ST_HALT: begin
        if (rst_ff)
          nxt_state = ST_STABR;
        else if (halt_wake)
          nxt_state = ST_STABI;
      end
      ST_AUTO_WAKEUP_HALT_MODE: begin
        if (rst_ff)
          nxt_state = ST_STABR;
        else if (halt_wake || awu_irq_i)
          nxt_state = ST_STABI;
      end
      ST_AHALT: begin
        if (rst_ff)
          nxt_state = ST_STABR;
        else if (ahalt_wake)
          nxt_state = ST_RUN;
      end
      ST_STABI, ST_STABR: begin
        if (tick && stab_ff == stab_last)
          nxt_state = ST_RUN;
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  // ****************************************
  // State, mask and counters
  // ****************************************
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= ST_RUN;
      imask_ff <= 1'b1;
      div_ff   <= 5'h00;
      stab_ff  <= 13'h0000;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_RUN && nxt_state != ST_RUN)
        imask_ff <= 1'b0;
      else if (irq_take_i)
        imask_ff <= 1'b1;
      else if (cc_pop_i)
        imask_ff <= 1'b0;
      // Divider is held at zero while the oscillator is off
      // Restart on stabilisation entry so the wait is whole CPU cycles
      if (state_ff == ST_HALT || state_ff == ST_AUTO_WAKEUP_HALT_MODE || tick ||
          (nxt_state != state_ff && (nxt_state == ST_STABI || nxt_state == ST_STABR)))
        div_ff <= 5'h00;
      else
        div_ff <= div_ff + 5'h01;
      if (state_ff != ST_STABI && state_ff != ST_STABR)
        stab_ff <= 13'h0000;
      else if (tick)
        stab_ff <= stab_ff + 13'h0001;
    end
  end

  // ****************************************
  // Clock enables and event pulses
  // ****************************************
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      osc_ff    <= 1'b1;
      cpu_en_ff <= 1'b0;
      per_en_ff <= 1'b0;
      tmr_en_ff <= 1'b0;
      fetch_ff  <= 1'b0;
      svc_ff    <= 1'b0;
      wdg_ff    <= 1'b0;
    end else begin
      osc_ff    <= nxt_state != ST_HALT && nxt_state != ST_AUTO_WAKEUP_HALT_MODE;
      cpu_en_ff <= tick && state_ff == ST_RUN;
      per_en_ff <= tick && (state_ff == ST_RUN || state_ff == ST_WAIT);
      tmr_en_ff <= tick && (state_ff == ST_RUN || state_ff == ST_WAIT ||
                            state_ff == ST_AHALT);
      fetch_ff  <= state_ff == ST_STABR && nxt_state == ST_RUN;
      svc_ff    <= (state_ff != ST_RUN && state_ff != ST_STABR) &&
                   nxt_state == ST_RUN;
      wdg_ff    <= state_ff == ST_RUN && halt_instr && !ahalt_en && wdg_trip;
    end
  end

  assign rdata_o         = rdata_ff;
  assign osc_run_o       = osc_ff;
  assign cpu_clk_en_o    = cpu_en_ff;
  assign periph_clk_en_o = per_en_ff;
  assign timer_clk_en_o  = tmr_en_ff;
  assign imask_o         = imask_ff;
  assign mode_o          = state_ff;
  assign wake_line_o     = wake_ff;
  assign fetch_reset_o   = fetch_ff;
  assign service_irq_o   = svc_ff;
  assign wdg_reset_o     = wdg_ff;

endmodule

`default_nettype wire

/* File: testbench/power_mode_sequencer_assertions.sv */
// Purpose: Port assertions for the power mode sequencer
// Assumes: Bound to every power_mode_sequencer instance
// Notes: A helper counter times the stabilisation wait
`default_nettype none
module power_mode_checker #(
  parameter integer STAB_SHORT = 256,
  parameter integer STAB_LONG  = 4096
) (
  // Clock, reset and requests
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       instr_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic       wfi_exec_i,
  input wire logic       timebase_one_interrupt_i,
  input wire logic       wdg_enable_i,
  input wire logic       watchdog_in_halt_option_i,
  input wire logic       stab_long_i,
  // Outputs
  input wire logic       osc_run_o,
  input wire logic       cpu_clk_en_o,
  input wire logic       periph_clk_en_o,
  input wire logic       imask_o,
  input wire logic [2:0] mode_o,
  input wire logic       service_irq_o,
  input wire logic       wdg_reset_o
);
  // ****************************************
  // Stabilisation counter
  // ****************************************
  logic [15:0] stab_cnt_ff;
  wire         in_stab  = mode_o == 3'h5 || mode_o == 3'h6;
  wire         halt_op  = instr_valid_i && opcode_i == 8'h8E && mode_o == 3'h0;
  wire  [15:0] stab_lim = 16'(stab_long_i ? 2 * STAB_LONG : 2 * STAB_SHORT);
  always @(posedge clk_i) begin
    stab_cnt_ff <= (sys_rst_i || !in_stab) ? 16'h0 : stab_cnt_ff + 16'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ****************************************
  // Assertions
  // ****************************************
  halt_mask_a: assert property (halt_op && !wdg_enable_i |=> !imask_o)
    else $error("mask kept on halt");
  wfi_entry_a: assert property (wfi_exec_i && !halt_op && mode_o == 3'h0 |=> mode_o == 3'h1 && !imask_o)
    else $error("wait entry wrong");
  osc_off_a: assert property (mode_o == 3'h2 || mode_o == 3'h4 |-> !osc_run_o)
    else $error("oscillator runs in halt");
  ahalt_clocks_a: assert property (mode_o == 3'h3 && $past(mode_o) == 3'h3 |->
    osc_run_o && !cpu_clk_en_o && !periph_clk_en_o)
    else $error("clocks wrong in active halt");
  ahalt_wake_a: assert property (mode_o == 3'h3 && timebase_one_interrupt_i |=>
    mode_o == 3'h0 && service_irq_o)
    else $error("active halt wake late");
  wdg_trip_a: assert property (halt_op && wdg_enable_i && watchdog_in_halt_option_i |=>
    mode_o == 3'h3 || (mode_o == 3'h0 && wdg_reset_o))
    else $error("watchdog halt wrong");
  stab_bound_a: assert property (in_stab |-> stab_cnt_ff < stab_lim)
    else $error("stabilisation too long");
  stab_end_a: assert property (in_stab && stab_cnt_ff == stab_lim - 16'h1 |=> mode_o == 3'h0)
    else $error("stabilisation end wrong");
endmodule
bind power_mode_sequencer power_mode_checker #(.STAB_SHORT(STAB_SHORT), .STAB_LONG(STAB_LONG))
  i_power_mode_checker (.*);
`default_nettype wire

/* File: testbench/power_mode_sequencer_tb.sv */
// Purpose: Self-checking bench for the power mode sequencer
// Assumes: Stabilisation counts shortened to 4 and 8
// Notes: Pin mux cases run from a table
`include "power_mode_defs.vh"
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value at %0t: got %h want %h", $time, got, exp); end end
module power_mode_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] sel; logic [7:0] pa; logic [3:0] pb; logic [2:0] wl;} row_t;
  row_t rows [8] = '{'{8'h00, 8'h11, 4'h1, 3'h7}, '{8'h15, 8'h22, 4'h2, 3'h7}, '{8'h2A, 8'h44, 4'h4, 3'h7},
    '{8'h3F, 8'h88, 4'h8, 3'h7}, '{8'h00, 8'hEE, 4'hE, 3'h0}, '{8'h15, 8'hDD, 4'hD, 3'h0},
    '{8'h2A, 8'hBB, 4'hB, 3'h0}, '{8'h3F, 8'h77, 4'h7, 3'h0}};
  logic [7:0] tcode [5] = '{8'h01, 8'h06, 8'h0E, 8'h02, 8'h04};
  int         n_fail = 0, tests_run = 0, w, f, s, st, c, p;
  logic [2:0] m, ext_irq_i;
  logic       clk_i, sys_rst_i, wr_i, rd_i, instr_valid_i, wfi_exec_i, irq_take_i, cc_pop_i, irq_pending_i;
  logic       periph_halt_wake_i, awu_irq_i, timebase_one_interrupt_i, ahalt_cap_irq_i, ext_rst_req_i;
  logic       wdg_enable_i, watchdog_in_halt_option_i, stab_long_i;
  logic [1:0] addr_i;
  logic [6:3] port_b_i;
  logic [7:0] wdata_i, opcode_i, port_a_i;
  wire  [7:0] rdata_o;
  wire  [2:0] mode_o, wake_line_o;
  wire        osc_run_o, cpu_clk_en_o, periph_clk_en_o, timer_clk_en_o, imask_o;
  wire        fetch_reset_o, service_irq_o, wdg_reset_o;

  power_mode_sequencer #(.STAB_SHORT(4), .STAB_LONG(8)) i_power_mode_sequencer (.*);

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ****************************************
  // Bus and observation tasks
  // ****************************************
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    `CHK(rdata_o, e)
  endtask
  task automatic op(input logic [7:0] o);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    opcode_i      <= o;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
  endtask
  // Counts pulses and stabilisation cycles over n cycles
  task automatic seen(input int n);
    {w, f, s, st, c, p} = '0;
    repeat (n) begin
      @(negedge clk_i);
      w  += wdg_reset_o;
      f  += fetch_reset_o;
      s  += service_irq_o;
      st += (mode_o === 3'h5 || mode_o === 3'h6);
      c  += cpu_clk_en_o;
      p  += periph_clk_en_o;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {sys_rst_i, port_a_i, port_b_i} = {1'b1, 8'h81, 4'h1};
    {wr_i, rd_i, instr_valid_i, wfi_exec_i, irq_take_i, cc_pop_i, irq_pending_i, awu_irq_i} = '0;
    {periph_halt_wake_i, timebase_one_interrupt_i, ahalt_cap_irq_i, ext_rst_req_i} = '0;
    {wdg_enable_i, watchdog_in_halt_option_i, stab_long_i, addr_i, ext_irq_i, wdata_i, opcode_i} = '0;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(`WAKE_PIN_SELECT_ADDR, 8'h0C);
    rd(`MAIN_CLOCK_CTRL_ADDR, 8'h00);
    rd(`MODE_STATUS_ADDR, 8'h10);
    seen(64);
    `CHK(wake_line_o, 3'h7)
    `CHK(c, 32)
    `CHK(p, 32)
    foreach (rows[i]) begin
      wr(`WAKE_PIN_SELECT_ADDR, rows[i].sel);
      port_a_i <= rows[i].pa;
      port_b_i <= rows[i].pb;
      seen(6);
      `CHK(wake_line_o, rows[i].wl)
      rd(`WAKE_PIN_SELECT_ADDR, rows[i].sel);
    end
    @(posedge clk_i);
    cc_pop_i <= 1'b1;
    @(posedge clk_i);
    cc_pop_i <= 1'b0;
    op(8'h8F);
    seen(2);
    `CHK(imask_o, 1'b0)
    `CHK(mode_o, 3'h0)
    @(posedge clk_i);
    irq_take_i <= 1'b1;
    @(posedge clk_i);
    irq_take_i <= 1'b0;
    seen(2);
    `CHK(imask_o, 1'b1)
    wr(`MAIN_CLOCK_CTRL_ADDR, 8'h01);
    seen(40);
    seen(64);
    `CHK(c, 2)
    @(posedge clk_i);
    wfi_exec_i <= 1'b1;
    @(posedge clk_i);
    wfi_exec_i <= 1'b0;
    rd(`MODE_STATUS_ADDR, 8'h09);
    seen(64);
    `CHK(c, 0)
    `CHK(p, 2)
    @(posedge clk_i);
    irq_pending_i <= 1'b1;
    seen(4);
    `CHK(mode_o, 3'h0)
    @(posedge clk_i);
    irq_pending_i <= 1'b0;
    wr(`MAIN_CLOCK_CTRL_ADDR, 8'h00);
    seen(40);
    seen(64);
    `CHK(c, 32)
    foreach (tcode[i]) begin
      m = (tcode[i][0] || (tcode[i][1] && tcode[i][2] && !tcode[i][3])) ? 3'h3 : 3'h2;
      wr(`TIMER_CTRL_ADDR, tcode[i]);
      stab_long_i <= (i == 2);
      op(`HALT_OPCODE);
      seen(2);
      `CHK(mode_o, m)
      `CHK(imask_o, 1'b0)
      `CHK(osc_run_o, m == 3'h3)
      @(posedge clk_i);
      timebase_one_interrupt_i <= (m == 3'h3);
      ext_irq_i <= {2'b00, m == 3'h2};
      seen(40);
      `CHK(st, (m == 3'h3) ? 0 : ((i == 2) ? 16 : 8))
      if (m == 3'h3) `CHK(s, 1)
      `CHK(mode_o, 3'h0)
      @(posedge clk_i);
      timebase_one_interrupt_i <= 1'b0;
      ext_irq_i <= 3'h0;
    end
    wr(`WAKE_PIN_SELECT_ADDR, 8'h1C);
    wr(`TIMER_CTRL_ADDR, 8'h00);
    op(`HALT_OPCODE);
    ext_irq_i <= 3'h4;
    seen(20);
    `CHK(mode_o, 3'h2)
    @(posedge clk_i);
    ext_irq_i <= 3'h5;
    seen(30);
    `CHK(mode_o, 3'h0)
    @(posedge clk_i);
    ext_irq_i <= 3'h0;
    wdg_enable_i <= 1'b1;
    watchdog_in_halt_option_i <= 1'b1;
    op(`HALT_OPCODE);
    seen(4);
    `CHK(w, 1)
    `CHK(mode_o, 3'h0)
    wr(`TIMER_CTRL_ADDR, 8'h01);
    op(`HALT_OPCODE);
    seen(4);
    `CHK(w, 0)
    `CHK(mode_o, 3'h3)
    @(posedge clk_i);
    ext_rst_req_i <= 1'b1;
    seen(30);
    `CHK(st, 8)
    `CHK(f, 1)
    @(posedge clk_i);
    ext_rst_req_i <= 1'b0;
    watchdog_in_halt_option_i <= 1'b0;
    wr(`TIMER_CTRL_ADDR, 8'h00);
    wr(`MAIN_CLOCK_CTRL_ADDR, 8'h02);
    op(`HALT_OPCODE);
    seen(4);
    `CHK(mode_o, 3'h4)
    `CHK(w, 0)
    @(posedge clk_i);
    awu_irq_i <= 1'b1;
    seen(30);
    `CHK(st, 8)
    `CHK(mode_o, 3'h0)
    wr(`MAIN_CLOCK_CTRL_ADDR, 8'h01);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(`MAIN_CLOCK_CTRL_ADDR, 8'h00);
    rd(`MODE_STATUS_ADDR, 8'h10);
    wrap_up;
  end
endmodule
`default_nettype wire
